// *** src/gpeu_top.sv ***
// Pin unit: enable, direction, level, edge flags, pass-through events.
// Assumes an APB master on i_clk_sys; pins are asynchronous.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module gpeu_top #(
    parameter int WIDTH = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_pin,
    output logic [WIDTH-1:0] o_pin_oe_n,
    input wire logic i_logic_combined_event,
    output logic [WIDTH-1:0] o_dma_event,
    output logic [WIDTH-1:0] o_cpu_event,
    output logic o_irq
);
    // ------------------------------------------------------------
    // Registers and internal signals
    // ------------------------------------------------------------
    logic [WIDTH-1:0] pin_enable_reg;
    logic [WIDTH-1:0] pin_direction_reg;
    logic [WIDTH-1:0] pin_level_reg;
    logic [WIDTH-1:0] rise_seen_reg;
    logic [WIDTH-1:0] fall_seen_reg;
    logic [WIDTH-1:0] edge_polarity_reg;
    logic [1:0] global_ctrl_reg;
    logic [WIDTH-1:0] irq_status_reg;
    logic [WIDTH-1:0] irq_enable_reg;
    logic [WIDTH-1:0] pin_sync;
    logic [WIDTH-1:0] rise_pulse;
    logic [WIDTH-1:0] fall_pulse;
    logic [WIDTH-1:0] watch_mask;
    logic [WIDTH-1:0] per_pin_event;
    logic [WIDTH-1:0] event_vec;
    logic logic_sync_meta_reg;
    logic logic_sync_reg;
    logic logic_prev_reg;
    logic logic_pulse;
    logic event_line_zero;
    logic wr_access;
    logic rd_access;
    logic addr_ok;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // Input capture
    // ------------------------------------------------------------
    gpeu_sync #(.WIDTH(WIDTH)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_async(i_pin),
        .o_sync(pin_sync)
    );
    gpeu_edge #(.WIDTH(WIDTH)) u_edge (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_level(pin_sync),
        .o_rise(rise_pulse),
        .o_fall(fall_pulse)
    );

    // Logic output may come from another block; treat as async
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            logic_sync_meta_reg <= 1'b0;
            logic_sync_reg <= 1'b0;
            logic_prev_reg <= 1'b0;
        end else if (i_ce) begin
            logic_sync_meta_reg <= i_logic_combined_event;
            logic_sync_reg <= logic_sync_meta_reg;
            logic_prev_reg <= logic_sync_reg;
        end
    end
    // Pulse on the rising edge only, so a held level gives one event
    assign logic_pulse = i_ce & logic_sync_reg & ~logic_prev_reg;

    // Only enabled inputs are watched
    assign watch_mask = pin_enable_reg & ~pin_direction_reg;
    // Edge by polarity, output pins give none
    assign per_pin_event = watch_mask &
        ((rise_pulse & ~edge_polarity_reg) |
         (fall_pulse & edge_polarity_reg));
    // Event0 source select
    assign event_line_zero =
        global_ctrl_reg[gpeu_pkg::BIT_EVENT0_SOURCE_SELECT] ?
        logic_pulse : per_pin_event[0];
    assign event_vec = {per_pin_event[WIDTH-1:1], event_line_zero};

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign wr_access = i_ce & i_psel & i_penable & i_pwrite;
    assign rd_access = i_ce & i_psel & ~i_penable & ~i_pwrite;

    // Read mux; level bit shows pin for inputs
    always_comb begin
        rd_mux = 32'h00000000;
        addr_ok = 1'b1;
        unique case (i_paddr)
            gpeu_pkg::OFF_PIN_ENABLE: rd_mux[WIDTH-1:0] = pin_enable_reg;
            gpeu_pkg::OFF_PIN_DIRECTION:
                rd_mux[WIDTH-1:0] = pin_direction_reg;
            gpeu_pkg::OFF_PIN_LEVEL: rd_mux[WIDTH-1:0] =
                (pin_direction_reg & pin_level_reg) |
                (~pin_direction_reg & pin_sync);
            gpeu_pkg::OFF_RISE_SEEN: rd_mux[WIDTH-1:0] = rise_seen_reg;
            gpeu_pkg::OFF_FALL_SEEN: rd_mux[WIDTH-1:0] = fall_seen_reg;
            gpeu_pkg::OFF_GLOBAL_CTRL: rd_mux[1:0] = global_ctrl_reg;
            gpeu_pkg::OFF_EDGE_POLARITY:
                rd_mux[WIDTH-1:0] = edge_polarity_reg;
            gpeu_pkg::OFF_IRQ_STATUS: rd_mux[WIDTH-1:0] = irq_status_reg;
            gpeu_pkg::OFF_IRQ_CLEAR: rd_mux = 32'h00000000;
            gpeu_pkg::OFF_IRQ_ENABLE: rd_mux[WIDTH-1:0] = irq_enable_reg;
            default: addr_ok = 1'b0;
        endcase
    end

    // Read data registered in setup, so access phase is zero-wait
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h00000000;
        end else if (rd_access) begin
            o_prdata <= rd_mux;
        end
    end

    // Ready and error answer in access phase
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else if (i_ce) begin
            o_pready <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & ~addr_ok;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Writes land only at the access edge, while pready stands high
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_enable_reg <= gpeu_pkg::RST_PINS;
            pin_direction_reg <= gpeu_pkg::RST_PINS;
            pin_level_reg <= gpeu_pkg::RST_PINS;
            edge_polarity_reg <= gpeu_pkg::RST_PINS;
            global_ctrl_reg <= gpeu_pkg::RST_GLOBAL_CTRL;
            irq_enable_reg <= gpeu_pkg::RST_PINS;
        end else if (wr_access && o_pready) begin
            unique case (i_paddr)
                gpeu_pkg::OFF_PIN_ENABLE:
                    pin_enable_reg <= i_pwdata[WIDTH-1:0];
                gpeu_pkg::OFF_PIN_DIRECTION:
                    pin_direction_reg <= i_pwdata[WIDTH-1:0];
                gpeu_pkg::OFF_PIN_LEVEL:
                    pin_level_reg <= i_pwdata[WIDTH-1:0];
                gpeu_pkg::OFF_EDGE_POLARITY:
                    edge_polarity_reg <= i_pwdata[WIDTH-1:0];
                gpeu_pkg::OFF_GLOBAL_CTRL:
                    global_ctrl_reg <= i_pwdata[1:0];
                gpeu_pkg::OFF_IRQ_ENABLE:
                    irq_enable_reg <= i_pwdata[WIDTH-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sticky edge flags: set wins over a write-one clear
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rise_seen_reg <= gpeu_pkg::RST_PINS;
        end else if (i_ce) begin
            rise_seen_reg <= ((wr_access && o_pready &&
                i_paddr == gpeu_pkg::OFF_RISE_SEEN) ?
                rise_seen_reg & ~i_pwdata[WIDTH-1:0] : rise_seen_reg)
                | (rise_pulse & watch_mask);
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fall_seen_reg <= gpeu_pkg::RST_PINS;
        end else if (i_ce) begin
            fall_seen_reg <= ((wr_access && o_pready &&
                i_paddr == gpeu_pkg::OFF_FALL_SEEN) ?
                fall_seen_reg & ~i_pwdata[WIDTH-1:0] : fall_seen_reg)
                | (fall_pulse & watch_mask);
        end
    end

    // Interrupt status: sticky per event, write-one clear, set wins
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_status_reg <= gpeu_pkg::RST_PINS;
        end else if (i_ce) begin
            irq_status_reg <= ((wr_access && o_pready &&
                i_paddr == gpeu_pkg::OFF_IRQ_CLEAR) ?
                irq_status_reg & ~i_pwdata[WIDTH-1:0] : irq_status_reg)
                | event_vec;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // Pins and events; pin0 may carry the logic output
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin <= '0;
            o_pin_oe_n <= '1;
            o_dma_event <= '0;
            o_cpu_event <= '0;
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_pin <= pin_level_reg;
            o_pin_oe_n <= ~(pin_enable_reg & pin_direction_reg);
            if (global_ctrl_reg[gpeu_pkg::BIT_PIN0_OUTPUT_SELECT]) begin
                o_pin[0] <= logic_sync_reg;
                o_pin_oe_n[0] <= 1'b0;
            end
            o_dma_event <= event_vec;
            o_cpu_event <= event_vec & gpeu_pkg::CPU_IRQ_MAP;
            o_irq <= |((irq_status_reg | event_vec) & irq_enable_reg);
        end else begin
            o_dma_event <= '0;
            o_cpu_event <= '0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Each check but chk_cpu_map_gap (bits 3:1) watches one pin; only chk_rise_sets, chk_fall_sets and chk_event_single stand for the whole vector
    chk_out_no_event: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        (i_ce && pin_direction_reg[1]) |=> !o_dma_event[1])
        else $error("event raised on output pin");
    chk_cpu_map_gap: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n) o_cpu_event[3:1] == 3'h0)
        else $error("cpu event on unmapped source");
    chk_event_single: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n) o_dma_event[3] |=> !o_dma_event[3])
        else $error("event longer than one cycle");
    chk_rise_sets: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        (rise_pulse[3] && watch_mask[3]) |=> rise_seen_reg[3])
        else $error("rise flag not set");
    chk_fall_sets: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        (fall_pulse[3] && watch_mask[3]) |=> fall_seen_reg[3])
        else $error("fall flag not set");
    chk_rise_event: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        (rise_pulse[5] && watch_mask[5] && !edge_polarity_reg[5]
         && i_ce) |=> o_dma_event[5] && o_cpu_event[5])
        else $error("rising event missing");
    chk_ev0_logic: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        (global_ctrl_reg[1] && per_pin_event[0] && !logic_pulse)
        |=> !o_dma_event[0])
        else $error("pin0 event leaked while logic selected");
    chk_drive_level: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        (i_ce && pin_enable_reg[2] && pin_direction_reg[2])
        |=> !o_pin_oe_n[2] && o_pin[2] == $past(pin_level_reg[2]))
        else $error("output pin not driven from level bit");
endmodule : gpeu_top
`default_nettype wire

// *** pkg/gpeu_pkg.sv ***
// Constants and register map of the pin and edge event unit.
// Assumes an APB slave with 32-bit data, one aligned word per register.
`default_nettype none
package gpeu_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_PIN_ENABLE = 8'h00;
    localparam logic [7:0] OFF_PIN_DIRECTION = 8'h04;
    localparam logic [7:0] OFF_PIN_LEVEL = 8'h08;
    localparam logic [7:0] OFF_RISE_SEEN = 8'h0C;
    localparam logic [7:0] OFF_FALL_SEEN = 8'h10;
    localparam logic [7:0] OFF_GLOBAL_CTRL = 8'h14;
    localparam logic [7:0] OFF_EDGE_POLARITY = 8'h18;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h1C;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h20;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h24;
    // ------------------------------------------------------------
    // Global control field positions
    // ------------------------------------------------------------
    localparam int BIT_PIN0_OUTPUT_SELECT = 0;
    localparam int BIT_EVENT0_SOURCE_SELECT = 1;
    // ------------------------------------------------------------
    // Reset values and CPU interrupt source map
    // ------------------------------------------------------------
    localparam logic [15:0] RST_PINS = 16'h0000;
    localparam logic [1:0] RST_GLOBAL_CTRL = 2'h0;
    localparam logic [15:0] CPU_IRQ_MAP = 16'h00F1;
    localparam int SYNC_STAGES = 2;
endpackage : gpeu_pkg
`default_nettype wire

// *** src/gpeu_sync.sv ***
// Two-flop synchroniser for a vector of pins.
// Assumes the inputs are asynchronous to i_clk_sys.
`timescale 1ns/1ps
`default_nettype none
module gpeu_sync #(
    parameter int WIDTH = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    // First stage read only by second stage
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= '0;
            o_sync <= '0;
        end else if (i_ce) begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule : gpeu_sync
`default_nettype wire

// *** src/gpeu_edge.sv ***
// Edge detector on synchronised pins: one-cycle rise and fall pulses.
// Assumes inputs are already in the i_clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module gpeu_edge #(
    parameter int WIDTH = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [WIDTH-1:0] i_level,
    output logic [WIDTH-1:0] o_rise,
    output logic [WIDTH-1:0] o_fall
);
    logic [WIDTH-1:0] prev_reg;
    // Previous sample for comparison
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_reg <= '0;
        end else if (i_ce) begin
            prev_reg <= i_level;
        end
    end
    // Compare current with previous sample
    assign o_rise = i_ce ? (i_level & ~prev_reg) : '0;
    assign o_fall = i_ce ? (~i_level & prev_reg) : '0;
endmodule : gpeu_edge
`default_nettype wire

// *** sim/gpeu_far_model.sv ***
// Far side of the pin unit: board pin wires and the event sinks.
// Assumes events are pulses sampled on the rising edge of i_clk_sys.
`timescale 1ns/1ps
`default_nettype none
module gpeu_far_model (
    input wire logic i_clk_sys,
    input wire logic i_clear,
    input wire logic [15:0] i_drive,
    input wire logic [15:0] i_pin_out,
    input wire logic [15:0] i_pin_oe_n,
    input wire logic [15:0] i_dma_event,
    input wire logic [15:0] i_cpu_event,
    output logic [15:0] o_wire,
    output logic [15:0] o_dma_seen,
    output logic [15:0] o_cpu_seen,
    output logic [7:0] o_dma_count
);
    // ------------------------------------------------------------
    // Pin wires and event sinks
    // ------------------------------------------------------------
    // Unit wins where it drives; the board drives every other pin
    assign o_wire = (~i_pin_oe_n & i_pin_out) | (i_pin_oe_n & i_drive);
    // Count every pulse, so a stretched event shows as extra counts
    always_ff @(posedge i_clk_sys) begin
        if (i_clear) begin
            o_dma_seen <= 16'h0000;
            o_cpu_seen <= 16'h0000;
            o_dma_count <= 8'h00;
        end else begin
            o_dma_seen <= o_dma_seen | i_dma_event;
            o_cpu_seen <= o_cpu_seen | i_cpu_event;
            o_dma_count <= o_dma_count + 8'($countones(i_dma_event));
        end
    end
endmodule : gpeu_far_model
`default_nettype wire

// *** sim/gpeu_top_bench.sv ***
// Self-checking bench of the pin unit, driven over APB.
// Assumes the far model resolves pin wires and counts event pulses.
`timescale 1ns/1ps
`default_nettype none
module gpeu_top_bench;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clear = 1'b1;
    logic evt = 1'b0, pready, pslverr, irq, perr;
    logic ce = 1'b1;
    logic [7:0] paddr = 8'h00, dma_cnt;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] drive = 16'h0000, pout, oe_n, lvl, dma_ev, cpu_ev;
    logic [15:0] dma_seen, cpu_seen;
    int miscompares = 0, samples_checked = 0;
    // Clock at 50 MHz
    always #10 clk_sys = ~clk_sys;
    gpeu_top #(.WIDTH(16)) gpeu_top_inst (
        .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_ce(ce),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_pin(lvl),
        .o_pin(pout), .o_pin_oe_n(oe_n), .i_logic_combined_event(evt),
        .o_dma_event(dma_ev), .o_cpu_event(cpu_ev), .o_irq(irq));
    gpeu_far_model gpeu_far_model_inst (
        .i_clk_sys(clk_sys), .i_clear(clear), .i_drive(drive),
        .i_pin_out(pout), .i_pin_oe_n(oe_n), .i_dma_event(dma_ev),
        .i_cpu_event(cpu_ev), .o_wire(lvl), .o_dma_seen(dma_seen),
        .o_cpu_seen(cpu_seen), .o_dma_count(dma_cnt));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("Compared %0d, mismatched %0d", samples_checked,
                 miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    // One transfer; the request holds until pready is seen high
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            miscompares++;
            give_verdict();
        end else begin
            rd = prdata;
            perr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        check(rd, e);
    endtask : rdc
    // Clear the sink counts for one clock
    task automatic zap();
        clear <= 1'b1;
        tick(1);
        clear <= 1'b0;
    endtask : zap
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        tick(4);
        rst_n <= 1'b1;
        clear <= 1'b0;
        // Every register reads zero from reset, unmapped word refused
        for (int i = 0; i < 10; i++) begin
            rdc(8'(i * 4), 32'h0);
        end
        rdc(8'h28, 32'h0);
        check({31'h0, perr}, 32'h1);
        // Pin 15 is an output but stays off while disabled
        apb(gpeu_pkg::OFF_PIN_ENABLE, 1'b1, 32'h7FFF);
        apb(gpeu_pkg::OFF_PIN_DIRECTION, 1'b1, 32'h8007);
        apb(gpeu_pkg::OFF_PIN_LEVEL, 1'b1, 32'h0005);
        tick(2);
        check({16'h0, oe_n}, 32'hFFF8);
        check({16'h0, pout & 16'h0007}, 32'h5);
        // Inputs read back and set edge flags, disabled pin 15 ignored
        drive <= 16'hA5A0;
        tick(5);
        apb(gpeu_pkg::OFF_PIN_LEVEL, 1'b0, 32'h0);
        check(rd & 32'h7FF8, 32'h25A0);
        rdc(gpeu_pkg::OFF_RISE_SEEN, 32'h25A0);
        apb(gpeu_pkg::OFF_RISE_SEEN, 1'b1, 32'hFFFF);
        rdc(gpeu_pkg::OFF_RISE_SEEN, 32'h0);
        drive <= 16'h0000;
        tick(5);
        rdc(gpeu_pkg::OFF_FALL_SEEN, 32'h25A0);
        // Pass-through: rising on low polarity, falling on high
        apb(gpeu_pkg::OFF_PIN_DIRECTION, 1'b1, 32'h0006);
        apb(gpeu_pkg::OFF_EDGE_POLARITY, 1'b1, 32'h00F0);
        apb(gpeu_pkg::OFF_PIN_LEVEL, 1'b1, 32'h0002);
        tick(5);
        apb(gpeu_pkg::OFF_IRQ_CLEAR, 1'b1, 32'hFFFF);
        zap();
        drive <= 16'hFFFF;
        tick(6);
        check({16'h0, dma_seen}, 32'h7F09);
        check({16'h0, cpu_seen}, 32'h0001);
        check({24'h0, dma_cnt}, 32'h9);
        rdc(gpeu_pkg::OFF_RISE_SEEN, 32'h7FF9);
        zap();
        drive <= 16'h0000;
        tick(6);
        check({16'h0, dma_seen}, 32'h00F0);
        check({16'h0, cpu_seen}, 32'h00F0);
        // Output pins toggling give no event
        zap();
        apb(gpeu_pkg::OFF_PIN_LEVEL, 1'b1, 32'h0004);
        tick(6);
        check({16'h0, dma_seen}, 32'h0);
        // Status is sticky, masked by enable, cleared by write-one
        rdc(gpeu_pkg::OFF_IRQ_STATUS, 32'h7FF9);
        check({31'h0, irq}, 32'h0);
        apb(gpeu_pkg::OFF_IRQ_ENABLE, 1'b1, 32'h0010);
        tick(2);
        check({31'h0, irq}, 32'h1);
        apb(gpeu_pkg::OFF_IRQ_CLEAR, 1'b1, 32'h0010);
        tick(2);
        check({31'h0, irq}, 32'h0);
        rdc(gpeu_pkg::OFF_IRQ_STATUS, 32'h7FE9);
        rdc(gpeu_pkg::OFF_IRQ_CLEAR, 32'h0);
        // Event line zero follows its source select
        apb(gpeu_pkg::OFF_GLOBAL_CTRL, 1'b1, 32'h0002);
        zap();
        drive <= 16'h0001;
        tick(6);
        check({16'h0, dma_seen}, 32'h0);
        evt <= 1'b1;
        tick(6);
        check({16'h0, dma_seen}, 32'h0001);
        check({16'h0, cpu_seen}, 32'h0001);
        apb(gpeu_pkg::OFF_GLOBAL_CTRL, 1'b1, 32'h0000);
        evt <= 1'b0;
        tick(6);
        zap();
        evt <= 1'b1;
        tick(6);
        check({16'h0, dma_seen}, 32'h0);
        // Logic output carried out on pin 0
        apb(gpeu_pkg::OFF_GLOBAL_CTRL, 1'b1, 32'h0001);
        tick(5);
        check({16'h0, oe_n & 16'h0001}, 32'h0);
        check({16'h0, lvl & 16'h0001}, 32'h1);
        evt <= 1'b0;
        tick(5);
        check({16'h0, lvl & 16'h0001}, 32'h0);
        // Clock enable low freezes pin capture and events
        zap();
        ce <= 1'b0;
        drive <= 16'h0009;
        tick(6);
        check({24'h0, dma_cnt}, 32'h0);
        ce <= 1'b1;
        tick(6);
        check({16'h0, dma_seen}, 32'h0008);
        give_verdict();
    end
endmodule : gpeu_top_bench
`default_nettype wire
